// ---- logic/fnd_divider_top.sv ----
`timescale 1ns/1ps
module fnd_divider_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic reference_input,
  input wire logic vco_fb,
  output logic diff_ref_en,
  output logic ref_src_en,
  output logic prescaler_89,
  output logic [3:0] cp_current,
  output logic integer_mode,
  output logic pfd_tick,
  output logic fb_tick,
  output logic [16:0] n_active
);
  fnd_mod_if mi ();

  logic sclk_s1, sclk_s2, sclk_s3;
  logic sdat_s1, sdat_s2;
  logic ld_s1, ld_s2, ld_s3;
  logic ref_s1, ref_s2, ref_s3;
  logic vco_s1, vco_s2, vco_s3;
  logic [31:0] shift_q;
  logic [15:0] whole_q;
  logic presc_q, ref_mode_q;
  logic [23:0] mfrac_buf_q, mfrac_act_q;
  logic [13:0] afrac_buf_q, afrac_act_q, aden_buf_q, aden_act_q;
  logic [9:0] rdiv_buf_q, rdiv_act_q, rcnt_q;
  logic halve_buf_q, halve_act_q, dbl_buf_q, dbl_act_q, half_q;
  logic [3:0] cp_buf_q, cp_act_q;
  logic int_mode_q, pfd_q, fb_q;
  logic [16:0] fcnt_q;
  logic load_ev, commit, ref_ev, ref_ev2, fb_ev;
  logic [3:0] sel;
  logic [9:0] rlim;

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // Every pin passes two flops; a third stage, on all but sdata, only marks edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {sdat_s1, sdat_s2} <= 2'h0;
      {ld_s1, ld_s2, ld_s3} <= 3'h0;
      {ref_s1, ref_s2, ref_s3} <= 3'h0;
      {vco_s1, vco_s2, vco_s3} <= 3'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {sclk, sclk_s1, sclk_s2};
      {sdat_s1, sdat_s2} <= {sdata, sdat_s1};
      {ld_s1, ld_s2, ld_s3} <= {load_strobe, ld_s1, ld_s2};
      {ref_s1, ref_s2, ref_s3} <= {reference_input, ref_s1, ref_s2};
      {vco_s1, vco_s2, vco_s3} <= {vco_fb, vco_s1, vco_s2};
    end
  end

  assign load_ev = rise(ld_s2, ld_s3);
  assign sel = shift_q[fnd_pkg::CTRL_W-1:0];
  assign commit = load_ev && sel == fnd_pkg::REG_WHOLE;

  // Serial word, most significant bit first
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      shift_q <= 32'h00000000;
    end else if (rise(sclk_s2, sclk_s3)) begin
      shift_q <= {shift_q[30:0], sdat_s2};
    end
  end

  // Register latches, written on the load strobe edge; mode, prescaler and whole part act directly, the rest are staged
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      whole_q <= fnd_pkg::WHOLE_RST;
      presc_q <= 1'b0;
      mfrac_buf_q <= 24'h000000;
      afrac_buf_q <= 14'h0000;
      aden_buf_q <= fnd_pkg::ADEN_RST;
      ref_mode_q <= 1'b0;
      rdiv_buf_q <= fnd_pkg::RDIV_RST;
      halve_buf_q <= 1'b0;
      dbl_buf_q <= 1'b0;
      cp_buf_q <= fnd_pkg::CP_RST;
    end else if (load_ev) begin
      unique case (sel)
        fnd_pkg::REG_WHOLE: begin
          whole_q <= shift_q[fnd_pkg::WHOLE_LSB +: fnd_pkg::INT_W];
          presc_q <= shift_q[fnd_pkg::PRESC_BIT];
        end
        fnd_pkg::REG_MFRAC: begin
          mfrac_buf_q <= shift_q[fnd_pkg::MFRAC_LSB +: fnd_pkg::MFRAC_W];
        end
        fnd_pkg::REG_AUX: begin
          aden_buf_q <= shift_q[fnd_pkg::ADEN_LSB +: fnd_pkg::AUX_W];
          afrac_buf_q <= shift_q[fnd_pkg::AFRAC_LSB +: fnd_pkg::AUX_W];
        end
        fnd_pkg::REG_REF: begin
          ref_mode_q <= shift_q[fnd_pkg::REFMODE_BIT];
          rdiv_buf_q <= shift_q[fnd_pkg::RDIV_LSB +: fnd_pkg::RDIV_W];
          halve_buf_q <= shift_q[fnd_pkg::HALVE_BIT];
          dbl_buf_q <= shift_q[fnd_pkg::DBL_BIT];
          cp_buf_q <= shift_q[fnd_pkg::CP_LSB +: fnd_pkg::CP_W];
        end
        default: begin
          // Other latches belong to functions outside this block
        end
      endcase
    end
  end

  // Buffered set moves to the working copy only on a register zero write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mfrac_act_q <= 24'h000000;
      afrac_act_q <= 14'h0000;
      aden_act_q <= fnd_pkg::ADEN_RST;
      rdiv_act_q <= fnd_pkg::RDIV_RST;
      halve_act_q <= 1'b0;
      dbl_act_q <= 1'b0;
      cp_act_q <= fnd_pkg::CP_RST;
      int_mode_q <= 1'b1;
    end else if (commit) begin
      mfrac_act_q <= mfrac_buf_q;
      afrac_act_q <= afrac_buf_q;
      aden_act_q <= aden_buf_q;
      rdiv_act_q <= rdiv_buf_q;
      halve_act_q <= halve_buf_q;
      dbl_act_q <= dbl_buf_q;
      cp_act_q <= cp_buf_q;
      int_mode_q <= mfrac_buf_q == 24'h000000
                    && afrac_buf_q == 14'h0000;
    end
  end

  // Doubler counts both reference edges, halve drops every other one
  assign ref_ev = rise(ref_s2, ref_s3)
                  | (dbl_act_q & rise(ref_s3, ref_s2));
  assign ref_ev2 = halve_act_q ? (ref_ev & half_q) : ref_ev;
  // A zero ratio is not legal, so it acts as one
  assign rlim = (rdiv_act_q == 10'h000) ? 10'h001 : rdiv_act_q;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      half_q <= 1'b0;
    end else if (ref_ev) begin
      half_q <= ~half_q;
    end
  end

  // Reference counter, one comparison tick per rlim qualified edges
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rcnt_q <= 10'h000;
      pfd_q <= 1'b0;
    end else begin
      pfd_q <= 1'b0;
      if (ref_ev2) begin
        if (rcnt_q >= 10'(rlim - 10'h001)) begin
          rcnt_q <= 10'h000;
          pfd_q <= 1'b1;
        end else begin
          rcnt_q <= 10'(rcnt_q + 10'h001);
        end
      end
    end
  end

  // Feedback counter; modulus is reloaded once per feedback cycle as the modulator steps
  assign fb_ev = rise(vco_s2, vco_s3)
                 && fcnt_q >= 17'(mi.n_now - 17'h00001);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fcnt_q <= 17'h00000;
      fb_q <= 1'b0;
    end else begin
      fb_q <= fb_ev;
      if (fb_ev || commit) begin
        fcnt_q <= 17'h00000;
      end else if (rise(vco_s2, vco_s3)) begin
        fcnt_q <= 17'(fcnt_q + 17'h00001);
      end
    end
  end

  assign mi.step = fb_ev;
  assign mi.clear = commit;
  // New whole part lands on the commit edge, so pass it straight through
  assign mi.int_part = commit
                       ? shift_q[fnd_pkg::WHOLE_LSB +: fnd_pkg::INT_W]
                       : whole_q;
  assign mi.mfrac = mfrac_act_q;
  assign mi.afrac = afrac_act_q;
  assign mi.aden = aden_act_q;

  fnd_modulator u_mod (
    .clock(clock),
    .nrst(nrst),
    .m(mi.mod)
  );

  assign diff_ref_en = ref_mode_q;
  assign ref_src_en = ref_mode_q;
  assign prescaler_89 = presc_q;
  assign cp_current = cp_act_q;
  assign integer_mode = int_mode_q;
  assign pfd_tick = pfd_q;
  assign fb_tick = fb_q;
  assign n_active = mi.n_now;

  a_commit_only: assert property (@(posedge clock) disable iff (!nrst)
    !$stable(mfrac_act_q) || !$stable(rdiv_act_q) || !$stable(cp_act_q)
      |-> $past(commit))
    else $error("buffered setting moved without register zero write");
  a_load_mfrac: assert property (@(posedge clock) disable iff (!nrst)
    load_ev && sel == fnd_pkg::REG_MFRAC |=> mfrac_buf_q
      == $past(shift_q[fnd_pkg::MFRAC_LSB +: fnd_pkg::MFRAC_W]))
    else $error("main fraction latch not loaded");
  a_int_mode: assert property (@(posedge clock) disable iff (!nrst)
    integer_mode == (mfrac_act_q == 24'h000000 && afrac_act_q == 14'h0000))
    else $error("integer mode flag disagrees with fractions");
  a_rcnt_bound: assert property (@(posedge clock) disable iff (!nrst)
    rcnt_q < rlim |=> rcnt_q < rlim || $changed(rlim))
    else $error("reference counter passed its ratio");
  a_pfd_wrap: assert property (@(posedge clock) disable iff (!nrst)
    pfd_tick |-> rcnt_q == 10'h000 && $past(ref_ev2))
    else $error("comparison tick without qualified edge");
  a_diff_ref: assert property (@(posedge clock) disable iff (!nrst)
    load_ev && sel == fnd_pkg::REG_REF
      |=> diff_ref_en == $past(shift_q[fnd_pkg::REFMODE_BIT])
      && ref_src_en == diff_ref_en)
    else $error("reference mode not applied");
  a_fb_tick: assert property (@(posedge clock) disable iff (!nrst)
    fb_ev && !commit |=> fb_tick && fcnt_q == 17'h00000)
    else $error("feedback tick missing after full count");
  a_halve_gap: assert property (@(posedge clock) disable iff (!nrst)
    halve_act_q && ref_ev2 |=> !half_q)
    else $error("halve stage passed two edges in a row");
endmodule

// ---- logic/fnd_mod_if.sv ----
`timescale 1ns/1ps
interface fnd_mod_if;
  logic step;
  logic clear;
  logic [15:0] int_part;
  logic [23:0] mfrac;
  logic [13:0] afrac;
  logic [13:0] aden;
  logic [16:0] n_now;
  logic carry;
  modport ctrl (output step, clear, int_part, mfrac, afrac, aden,
                input n_now, carry);
  modport mod (input step, clear, int_part, mfrac, afrac, aden,
               output n_now, carry);
endinterface

// ---- logic/fnd_modulator.sv ----
`timescale 1ns/1ps
module fnd_modulator (
  input wire logic clock,
  input wire logic nrst,
  fnd_mod_if.mod m
);
  logic [13:0] aux_q;
  logic [23:0] main_q;
  logic [16:0] n_now_q;
  logic carry_q;
  logic [14:0] aux_sum;
  logic aux_c;
  logic [13:0] aux_d;
  logic [24:0] main_sum;

  // Auxiliary stage runs exactly over its own modulus, so no residue drifts
  always_comb begin
    aux_sum = {1'b0, aux_q} + {1'b0, m.afrac};
    aux_c = aux_sum >= {1'b0, m.aden};
    aux_d = aux_c ? 14'(aux_sum - {1'b0, m.aden}) : aux_sum[13:0];
    main_sum = {1'b0, main_q} + {1'b0, m.mfrac} + {24'h000000, aux_c};
  end

  // Accumulators advance once per feedback cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aux_q <= 14'h0000;
      main_q <= 24'h000000;
    end else if (m.clear) begin
      aux_q <= 14'h0000;
      main_q <= 24'h000000;
    end else if (m.step) begin
      aux_q <= aux_d;
      main_q <= main_sum[23:0];
    end
  end

  // Next division is the whole part plus the overflow of the 2^24 wrap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      n_now_q <= {1'b0, fnd_pkg::WHOLE_RST};
      carry_q <= 1'b0;
    end else if (m.clear) begin
      n_now_q <= {1'b0, m.int_part};
      carry_q <= 1'b0;
    end else if (m.step) begin
      n_now_q <= {1'b0, m.int_part} + {16'h0000, main_sum[24]};
      carry_q <= main_sum[24];
    end
  end

  assign m.n_now = n_now_q;
  assign m.carry = carry_q;

  a_mod_carry: assert property (@(posedge clock) disable iff (!nrst)
    m.step && !m.clear |=> n_now_q == {1'b0, $past(m.int_part)}
      + {16'h0000, carry_q})
    else $error("division does not follow carry");
  a_aux_range: assert property (@(posedge clock) disable iff (!nrst)
    m.aden >= 14'h0002 && $stable(m.aden) && aux_q < m.aden
      |=> aux_q < m.aden)
    else $error("auxiliary accumulator escaped its modulus");
  a_int_no_carry: assert property (@(posedge clock) disable iff (!nrst)
    m.step && m.mfrac == 24'h000000 && m.afrac == 14'h0000
      && main_q == 24'h000000 && aux_q == 14'h0000 |=> !carry_q)
    else $error("carry seen in integer mode");
endmodule

// ---- logic/fnd_pkg.sv ----
package fnd_pkg;
  localparam int WORD_W = 32;
  localparam int CTRL_W = 4;
  localparam int INT_W = 16;
  localparam int MFRAC_W = 24;
  localparam int AUX_W = 14;
  localparam int RDIV_W = 10;
  localparam int CP_W = 4;
  localparam int N_W = 17;
  // Register selects carried in the low control bits
  localparam logic [3:0] REG_WHOLE = 4'h0;
  localparam logic [3:0] REG_MFRAC = 4'h1;
  localparam logic [3:0] REG_AUX = 4'h2;
  localparam logic [3:0] REG_REF = 4'h4;
  // Field positions (low bit of each field)
  localparam int WHOLE_LSB = 4;
  localparam int PRESC_BIT = 20;
  localparam int MFRAC_LSB = 4;
  localparam int ADEN_LSB = 4;
  localparam int AFRAC_LSB = 18;
  localparam int REFMODE_BIT = 9;
  localparam int RDIV_LSB = 10;
  localparam int HALVE_BIT = 20;
  localparam int DBL_BIT = 21;
  localparam int CP_LSB = 22;
  // Reset values
  localparam logic [15:0] WHOLE_RST = 16'h0064;
  localparam logic [13:0] ADEN_RST = 14'h0002;
  localparam logic [9:0] RDIV_RST = 10'h001;
  localparam logic [3:0] CP_RST = 4'h0;
  // Fixed main denominator, two to the twenty-fourth
  localparam logic [24:0] MAIN_DEN = 25'h1000000;
endpackage

// ---- verification/fnd_divider_top_tb.sv ----
`timescale 1ns/1ps
module fnd_divider_top_tb;
  logic clock = 1'b0, nrst = 1'b0, reference_input = 1'b0, vco_fb = 1'b0;
  logic sclk, sdata, load_strobe, diff_ref_en, ref_src_en, prescaler_89;
  logic integer_mode, pfd_tick, fb_tick, smp = 1'b0, fb_run = 1'b0;
  logic [3:0] cp_current;
  logic [16:0] n_active;
  logic [11:0] pfd_c = 12'h000;
  logic [19:0] nsum = 20'h00000;
  logic [39:0] exp_q[$];
  int err_count = 0, tests_run = 0;
  logic [31:0] rs = 32'h00000002;
  logic [15:0] w;
  fnd_host_model host (.clock(clock), .sclk(sclk), .sdata(sdata),
    .load_strobe(load_strobe));
  fnd_divider_top uut (.clock(clock), .nrst(nrst), .sclk(sclk),
    .sdata(sdata), .load_strobe(load_strobe),
    .reference_input(reference_input), .vco_fb(vco_fb),
    .diff_ref_en(diff_ref_en), .ref_src_en(ref_src_en),
    .prescaler_89(prescaler_89), .cp_current(cp_current),
    .integer_mode(integer_mode), .pfd_tick(pfd_tick), .fb_tick(fb_tick),
    .n_active(n_active));
  always #12.5 clock = ~clock;
  // Feedback pin: a rise every six clocks while enabled
  initial forever begin
    repeat (3) @(negedge clock);
    vco_fb = fb_run ? ~vco_fb : 1'b0;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [39:0] mk(logic d, logic i, logic p,
      logic [3:0] cp, logic [11:0] pf, logic [19:0] ns);
    return {d, d, i, p, cp, pf, ns};
  endfunction
  // Watcher: counts ticks, sums divisions, compares on each sample
  always @(posedge clock) begin
    if (smp) begin
      tests_run++;
      if ({diff_ref_en, ref_src_en, integer_mode, prescaler_89, cp_current,
           pfd_c, nsum} !== exp_q[0]) begin
        err_count++;
        $display("Error %0t: outputs %h expected %h", $time,
          {diff_ref_en, ref_src_en, integer_mode, prescaler_89, cp_current,
           pfd_c, nsum}, exp_q[0]);
      end
      void'(exp_q.pop_front());
      pfd_c <= 12'h000;
      nsum <= 20'h00000;
    end else begin
      if (pfd_tick === 1'b1) pfd_c <= pfd_c + 12'h001;
      if (fb_tick === 1'b1) nsum <= nsum + {3'h0, n_active};
    end
  end
  task automatic check(input logic [39:0] e);
    @(negedge clock);
    exp_q.push_back(e);
    smp = 1'b1;
    @(negedge clock);
    smp = 1'b0;
  endtask
  task automatic ref_pulses(input int n);
    repeat (n) begin
      reference_input = 1'b1;
      repeat (4) @(negedge clock);
      reference_input = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask
  // Bounded wait for k feedback completions, then stop the pin
  task automatic wait_fb(input int k);
    int seen, t;
    seen = 0;
    t = 0;
    while (seen < k && t < 20000) begin
      @(posedge clock);
      #1;
      if (fb_tick === 1'b1) seen++;
      t++;
    end
    if (seen < k) begin
      err_count++;
      $display("Error %0t: feedback ticks missing", $time);
    end
    @(negedge clock);
    fb_run = 1'b0;
  endtask
  function automatic logic [31:0] reg0(logic [15:0] v, logic p);
    return ({16'h0000, v} << fnd_pkg::WHOLE_LSB) |
      ({31'h0, p} << fnd_pkg::PRESC_BIT);
  endfunction
  function automatic logic [31:0] reg4(logic m, logic [9:0] r, logic t,
      logic d, logic [3:0] cp);
    return ({31'h0, m} << fnd_pkg::REFMODE_BIT) |
      ({22'h0, r} << fnd_pkg::RDIV_LSB) | ({31'h0, t} << fnd_pkg::HALVE_BIT) |
      ({31'h0, d} << fnd_pkg::DBL_BIT) | ({28'h0, cp} << fnd_pkg::CP_LSB) |
      32'h00000004;
  endfunction
  task automatic stop_test();
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Timeout well above the roughly 9k cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    stop_test();
  end
  initial begin
    logic m;
    logic [23:0] f1;
    logic [11:0] exp_pfd;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    fb_run = 1'b1;
    wait_fb(2);
    check(mk(1'b0, 1'b1, 1'b0, 4'h0, 12'h000, 20'h000c8));
    // Mode bit acts at once; divider and pump wait for a register zero
    host.send(reg4(1'b1, 10'h003, 1'b0, 1'b0, 4'h5));
    host.send(32'hffff_fff3); // Unused code, ignored
    ref_pulses(12);
    check(mk(1'b1, 1'b1, 1'b0, 4'h0, 12'h00c, 20'h00000));
    w = 16'h0017 + 16'(rnd() % 40);
    // Remainder of one half, scaled by the fixed modulus
    f1 = 24'(fnd_pkg::MAIN_DEN >> 1);
    host.send({4'h0, f1, fnd_pkg::REG_MFRAC});
    // Largest auxiliary fraction staged, then replaced before the commit
    host.send(32'hfffc0022);
    host.send(32'h00000022);
    host.send(reg0(w, 1'b0));
    fb_run = 1'b1;
    ref_pulses(12);
    wait_fb(4);
    check(mk(1'b1, 1'b0, 1'b0, 4'h5, 12'h004, 20'(4 * w + 2)));
    // Every doubler and halve combination with divider three
    for (int k = 0; k < 4; k++) begin
      m = 1'(rnd() % 2);
      host.send(reg4(m, 10'h003, k[0], k[1], 4'h5));
      host.send(reg0(w, 1'b0));
      ref_pulses(12);
      exp_pfd = 12'(12 * (1 + k[1]) / (3 * (1 + k[0])));
      check(mk(m, 1'b0, 1'b0, 4'h5, exp_pfd, 20'h00000));
    end
    w = 16'h004b + 16'(rnd() % 20);
    host.send(32'h00000001);
    host.send(reg0(w, 1'b1));
    fb_run = 1'b1;
    wait_fb(3);
    check(mk(m, 1'b1, 1'b1, 4'h5, 12'h000, 20'(3 * w)));
    repeat (4) @(negedge clock);
    stop_test();
  end
endmodule

// ---- verification/fnd_host_model.sv ----
`timescale 1ns/1ps
// Host side of the three-wire port; pins change on the falling edge
module fnd_host_model (
  input wire logic clock,
  output logic sclk,
  output logic sdata,
  output logic load_strobe
);
  // Pins idle low before the first frame
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    load_strobe = 1'b0;
  end
  // Four clocks a level, one more than the synchroniser needs
  task automatic hold4();
    repeat (4) @(negedge clock);
  endtask
  // Whole word, then the strobe; only after the strobe drops may more follow
  task automatic send(input logic [31:0] word);
    for (int i = 31; i >= 0; i--) begin
      sdata = word[i];
      hold4();
      sclk = 1'b1;
      hold4();
      sclk = 1'b0;
    end
    sdata = ~word[0]; // Released line must not keep the last bit
    load_strobe = 1'b1;
    hold4();
    load_strobe = 1'b0;
    hold4();
  endtask
endmodule
